// file: sft_pkg.sv
package sft_pkg;

  // Core clock and the three selectable serial clock rates.
  localparam int CLK_MHZ = 250;
  localparam int SCLK_SLOW_MHZ = 20;
  localparam int SCLK_MID_MHZ = 33;
  localparam int SCLK_FAST_MHZ = 50;

  // Half periods round up, so the pin clock never runs faster than the chosen rate.
  localparam logic [3:0] HALF_SLOW = 4'((CLK_MHZ + 2 * SCLK_SLOW_MHZ - 1) / (2 * SCLK_SLOW_MHZ));
  localparam logic [3:0] HALF_MID = 4'((CLK_MHZ + 2 * SCLK_MID_MHZ - 1) / (2 * SCLK_MID_MHZ));
  localparam logic [3:0] HALF_FAST = 4'((CLK_MHZ + 2 * SCLK_FAST_MHZ - 1) / (2 * SCLK_FAST_MHZ));

  localparam logic [1:0] RATE_SLOW = 2'h0;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_FAST = 2'h2;

  // Address widths: three bytes reach 16 MB, four bytes reach 64 MB per select.
  localparam logic [2:0] ADDR_NONE = 3'h0;
  localparam logic [2:0] ADDR_THREE = 3'h3;
  localparam logic [2:0] ADDR_FOUR = 3'h4;
  localparam int ADDR_THREE_BITS = 24;
  localparam int ADDR_FOUR_BITS = 26;

  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [3:0] RX_BYTE_BITS = 4'h8;

  // Between transfers the out line is driven low and the other lines float.
  localparam logic [3:0] IDLE_OE = 4'h1;
  localparam logic [3:0] IDLE_IO = 4'h0;

  typedef enum logic [1:0] {
    TGT_PRIMARY = 2'h0,
    TGT_SECONDARY = 2'h1,
    TGT_TRUSTED = 2'h2,
    TGT_TOUCH = 2'h3
  } sft_target_e;

  typedef enum logic [2:0] {
    MODE_SINGLE = 3'h0,
    MODE_DUAL_OUT = 3'h1,
    MODE_DUAL_IO = 3'h2,
    MODE_QUAD_OUT = 3'h3,
    MODE_QUAD_IO = 3'h4
  } sft_mode_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA = 6'h10,
    ST_END = 6'h20
  } sft_state_e;

  typedef struct packed {
    sft_target_e target;
    sft_mode_e mode;
    logic isWrite;
    logic [2:0] addrBytes;
    logic [3:0] dummy;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [15:0] len;
  } sft_cmd_s;

  typedef struct packed {
    sft_state_e st;
    logic [31:0] sh;
    logic [5:0] bits;
    logic [2:0] lanes;
  } sft_phase_s;

  function automatic logic [2:0] addrLanes(input sft_mode_e m);
    case (m)
      MODE_DUAL_IO: addrLanes = 3'h2;
      MODE_QUAD_IO: addrLanes = 3'h4;
      default: addrLanes = 3'h1;
    endcase
  endfunction : addrLanes

  function automatic logic [2:0] dataLanes(input sft_mode_e m);
    case (m)
      MODE_DUAL_OUT, MODE_DUAL_IO: dataLanes = 3'h2;
      MODE_QUAD_OUT, MODE_QUAD_IO: dataLanes = 3'h4;
      default: dataLanes = 3'h1;
    endcase
  endfunction : dataLanes

  function automatic logic [3:0] laneMask(input logic [2:0] lanes);
    case (lanes)
      3'h2: laneMask = 4'h3;
      3'h4: laneMask = 4'hF;
      default: laneMask = 4'h1;
    endcase
  endfunction : laneMask

endpackage : sft_pkg

// file: sft_sync.sv
`timescale 1ns/1ps
module sft_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pin levels and their synchronised copies.
  input wire logic [WIDTH-1:0] pinLevel,
  output logic [WIDTH-1:0] syncLevel
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncLevel <= '0;
    end else begin
      stage1_r <= pinLevel;
      syncLevel <= stage1_r;
    end
  end

endmodule : sft_sync

// file: sft_buf.sv
`timescale 1ns/1ps
module sft_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side.
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [IDX_W:0] FULL = (IDX_W + 1)'(DEPTH);
  localparam logic [IDX_W-1:0] LAST = IDX_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [IDX_W-1:0] rdIdx_r;
  logic [IDX_W-1:0] wrIdx_r;
  logic [IDX_W:0] count_r;
  logic push;
  logic pop;

  function automatic logic [IDX_W-1:0] bump(input logic [IDX_W-1:0] idx);
    bump = (idx == LAST) ? '0 : idx + 1'b1;
  endfunction : bump

  assign inReady = count_r != FULL;
  assign outValid = count_r != '0;
  assign outData = mem_r[rdIdx_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrIdx_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdIdx_r <= '0;
      wrIdx_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrIdx_r <= bump(wrIdx_r);
      end
      if (pop) begin
        rdIdx_r <= bump(rdIdx_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : sft_buf

// file: sft_port.sv
`timescale 1ns/1ps
module sft_port
  import sft_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Straps and rate.
  input wire logic [1:0] rateSel,
  input wire logic strapTrustedOnPort,
  input wire logic strapFlashMultiLine,
  // Command request.
  input wire logic cmdValid,
  input wire sft_cmd_s cmd,
  output logic cmdReady,
  output logic cmdReject,
  output logic cmdDone,
  // Write data stream.
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  // Read data stream.
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic rxReady,
  // Flash port pins.
  output logic flashPortSerialClock,
  output logic primaryFlashSelectN,
  output logic secondaryFlashSelectN,
  output logic trustedModuleSelectN,
  output logic flashPortOutLineDrive,
  output logic flashPortOutLineEnable,
  input wire logic flashPortOutLineSense,
  output logic flashPortInLineDrive,
  output logic flashPortInLineEnable,
  input wire logic flashPortInLineSense,
  output logic [1:0] flashPortUpperDataDrive,
  output logic [1:0] flashPortUpperDataEnable,
  input wire logic [1:0] flashPortUpperDataSense,
  // Touch port pins.
  output logic touchPortSerialClock,
  output logic touchDeviceSelectN,
  output logic touchPortOutLineDrive,
  output logic touchPortOutLineEnable,
  input wire logic touchPortOutLineSense,
  output logic touchPortInLineDrive,
  output logic touchPortInLineEnable,
  input wire logic touchPortInLineSense,
  output logic touchPortDataBit2Drive,
  output logic touchPortDataBit2Enable,
  input wire logic touchPortDataBit2Sense,
  output logic touchPortDataBit3Drive,
  output logic touchPortDataBit3Enable,
  input wire logic touchPortDataBit3Sense
);

  sft_state_e state_r;
  sft_cmd_s cmd_r;
  logic [3:0] half_r;
  logic [3:0] divCnt_r;
  logic sclk_r;
  logic endHigh_r;
  logic [31:0] sh_r;
  logic [5:0] bitsLeft_r;
  logic [2:0] lanes_r;
  logic [15:0] bytesLeft_r;
  logic waitTx_r;
  logic [7:0] rxSh_r;
  logic [3:0] rxBits_r;
  logic rxPend_r;
  logic [7:0] rxByte_r;
  logic cmdReady_r;
  logic cmdReject_r;
  logic cmdDone_r;
  logic flashSclk_r;
  logic [2:0] flashSel_r;
  logic [3:0] flashIo_r;
  logic [3:0] flashOe_r;
  logic touchSclk_r;
  logic touchSel_r;
  logic [3:0] touchIo_r;
  logic [3:0] touchOe_r;

  logic [7:0] syncLines;
  logic [3:0] sense;
  logic tick;
  logic busy;
  logic shifting;
  logic stallNow;
  logic beatEnd;
  logic phaseDone;
  logic lastByte;
  logic accept;
  logic cmdOk;
  logic txTake;
  logic bufInReady;
  logic csAct;
  logic flashAct;
  logic touchAct;
  logic [3:0] oeAct;
  logic [3:0] drv;
  logic [3:0] halfSel;
  logic [7:0] rxNext;
  logic [3:0] rxCount;
  sft_phase_s phNext;

  // Picks the phase after the current one; a multi-line read with no dummy beats gets one turnaround beat.
  function automatic sft_phase_s nextPhase(input sft_state_e cur, input sft_cmd_s c);
    sft_phase_s p;
    logic [4:0] dum;
    p.st = ST_END;
    p.sh = 32'h0;
    p.bits = 6'h01;
    p.lanes = 3'h1;
    dum = {1'b0, c.dummy};
    if (dum == 5'h0 && !c.isWrite && c.mode != MODE_SINGLE) begin
      dum = 5'h01;
    end
    if (cur == ST_OPC && c.addrBytes != ADDR_NONE) begin
      p.st = ST_ADDR;
      p.sh = (c.addrBytes == ADDR_THREE) ? {c.addr[23:0], 8'h00} : c.addr;
      p.bits = {c.addrBytes, 3'h0};
      p.lanes = addrLanes(c.mode);
    end else if ((cur == ST_OPC || cur == ST_ADDR) && dum != 5'h0) begin
      p.st = ST_DUMMY;
      p.bits = {1'b0, dum};
    end else if (cur != ST_DATA && c.len != 16'h0) begin
      p.st = ST_DATA;
      p.bits = BYTE_BITS;
      p.lanes = dataLanes(c.mode);
    end
    return p;
  endfunction : nextPhase

  sft_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinLevel({touchPortDataBit3Sense, touchPortDataBit2Sense, touchPortInLineSense,
               touchPortOutLineSense, flashPortUpperDataSense, flashPortInLineSense,
               flashPortOutLineSense}),
    .syncLevel(syncLines)
  );

  // A receiver that stalls fills this buffer, which in turn holds the serial clock.
  sft_buf #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_rxbuf (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(rxPend_r),
    .inData(rxByte_r),
    .inReady(bufInReady),
    .outValid(rxValid),
    .outData(rxData),
    .outReady(rxReady)
  );

  always_comb begin
    case (rateSel)
      RATE_SLOW: halfSel = HALF_SLOW;
      RATE_MID: halfSel = HALF_MID;
      default: halfSel = HALF_FAST;
    endcase
  end

  always_comb begin
    cmdOk = rateSel != 2'h3;
    if (cmd.addrBytes == ADDR_THREE) begin
      cmdOk = cmdOk && (cmd.addr >> ADDR_THREE_BITS) == 32'h0;
    end else if (cmd.addrBytes == ADDR_FOUR) begin
      cmdOk = cmdOk && (cmd.addr >> ADDR_FOUR_BITS) == 32'h0;
    end else if (cmd.addrBytes != ADDR_NONE) begin
      cmdOk = 1'b0;
    end
    case (cmd.target)
      TGT_TRUSTED: cmdOk = cmdOk && strapTrustedOnPort && cmd.mode == MODE_SINGLE;
      TGT_TOUCH: cmdOk = cmdOk && cmd.mode inside {MODE_SINGLE, MODE_DUAL_IO, MODE_QUAD_IO};
      default: begin
        if (cmd.mode > MODE_DUAL_OUT || (cmd.isWrite && cmd.mode == MODE_DUAL_OUT)) begin
          cmdOk = cmdOk && strapFlashMultiLine;
        end
      end
    endcase
  end

  assign sense = (cmd_r.target == TGT_TOUCH) ? syncLines[7:4] : syncLines[3:0];
  assign busy = state_r != ST_IDLE;
  assign shifting = state_r inside {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA};
  assign tick = divCnt_r == half_r - 4'h1;
  assign stallNow = state_r == ST_DATA && !sclk_r &&
                    (waitTx_r || (!cmd_r.isWrite && rxBits_r == 4'h0 && rxPend_r));
  assign beatEnd = shifting && sclk_r && tick;
  assign phaseDone = beatEnd && bitsLeft_r == {3'h0, lanes_r};
  assign lastByte = bytesLeft_r == 16'h1;
  assign accept = cmdValid && cmdReady_r;
  assign txTake = waitTx_r && txValid;
  assign phNext = nextPhase(state_r, cmd_r);
  assign rxCount = rxBits_r + {1'b0, lanes_r};

  always_comb begin
    case (lanes_r)
      3'h2: rxNext = {rxSh_r[5:0], sense[1:0]};
      3'h4: rxNext = {rxSh_r[3:0], sense};
      default: rxNext = {rxSh_r[6:0], sense[1]};
    endcase
  end

  // Serial clock divider; the clock parks low while a stall holds the low phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt_r <= 4'h0;
      sclk_r <= 1'b0;
    end else begin
      divCnt_r <= (!busy || stallNow || tick) ? 4'h0 : divCnt_r + 4'h1;
      if (!shifting) begin
        sclk_r <= 1'b0;
      end else if (tick && !stallNow) begin
        sclk_r <= ~sclk_r;
      end
    end
  end

  // Transfer sequencer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cmd_r <= '0;
      half_r <= HALF_SLOW;
      sh_r <= 32'h0;
      bitsLeft_r <= 6'h0;
      lanes_r <= 3'h1;
      bytesLeft_r <= 16'h0;
      endHigh_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept && cmdOk) begin
            cmd_r <= cmd;
            half_r <= halfSel;
            state_r <= ST_OPC;
            sh_r <= {cmd.opcode, 24'h0};
            bitsLeft_r <= BYTE_BITS;
            lanes_r <= 3'h1;
          end
        end
        ST_OPC, ST_ADDR, ST_DUMMY: begin
          if (phaseDone) begin
            state_r <= phNext.st;
            sh_r <= phNext.sh;
            bitsLeft_r <= phNext.bits;
            lanes_r <= phNext.lanes;
            bytesLeft_r <= cmd_r.len;
          end else if (beatEnd) begin
            sh_r <= sh_r << lanes_r;
            bitsLeft_r <= bitsLeft_r - {3'h0, lanes_r};
          end
        end
        ST_DATA: begin
          if (txTake) begin
            sh_r <= {txData, 24'h0};
          end else if (phaseDone) begin
            if (lastByte) begin
              state_r <= ST_END;
            end
            bitsLeft_r <= BYTE_BITS;
            bytesLeft_r <= bytesLeft_r - 16'h1;
            sh_r <= sh_r << lanes_r;
          end else if (beatEnd) begin
            sh_r <= sh_r << lanes_r;
            bitsLeft_r <= bitsLeft_r - {3'h0, lanes_r};
          end
        end
        ST_END: begin
          if (tick) begin
            endHigh_r <= ~endHigh_r;
            if (endHigh_r) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Write data is asked for one byte at a time, at each byte boundary.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitTx_r <= 1'b0;
    end else if (txTake) begin
      waitTx_r <= 1'b0;
    end else if (phaseDone && cmd_r.isWrite) begin
      if ((state_r != ST_DATA && phNext.st == ST_DATA) || (state_r == ST_DATA && !lastByte)) begin
        waitTx_r <= 1'b1;
      end
    end
  end

  // Read bytes assemble msb first; a finished byte that the buffer takes late is kept.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxSh_r <= 8'h0;
      rxBits_r <= 4'h0;
      rxPend_r <= 1'b0;
      rxByte_r <= 8'h0;
    end else begin
      if (rxPend_r && bufInReady) begin
        rxPend_r <= 1'b0;
      end
      if (accept) begin
        rxBits_r <= 4'h0;
      end else if (beatEnd && state_r == ST_DATA && !cmd_r.isWrite) begin
        rxSh_r <= rxNext;
        if (rxCount == RX_BYTE_BITS) begin
          rxByte_r <= rxNext;
          rxPend_r <= 1'b1;
          rxBits_r <= 4'h0;
        end else begin
          rxBits_r <= rxCount;
        end
      end
    end
  end

  // Command handshake and status pulses.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdReady_r <= 1'b0;
      cmdReject_r <= 1'b0;
      cmdDone_r <= 1'b0;
    end else begin
      cmdReady_r <= state_r == ST_IDLE && !accept;
      cmdReject_r <= accept && !cmdOk;
      cmdDone_r <= state_r == ST_END && tick && endHigh_r;
    end
  end

  assign csAct = shifting || (state_r == ST_END && !endHigh_r);
  assign flashAct = csAct && cmd_r.target != TGT_TOUCH;
  assign touchAct = csAct && cmd_r.target == TGT_TOUCH;
  assign drv = (lanes_r == 3'h4) ? sh_r[31:28] :
               (lanes_r == 3'h2) ? {2'h0, sh_r[31:30]} : {3'h0, sh_r[31]};

  // Lines drive only in the phases where the controller owns them.
  always_comb begin
    case (state_r)
      ST_OPC, ST_ADDR: oeAct = laneMask(lanes_r);
      ST_DUMMY: oeAct = (cmd_r.mode == MODE_SINGLE) ? IDLE_OE : 4'h0;
      ST_DATA: begin
        if (cmd_r.isWrite) begin
          oeAct = laneMask(lanes_r);
        end else begin
          oeAct = (cmd_r.mode == MODE_SINGLE) ? IDLE_OE : 4'h0;
        end
      end
      ST_END: oeAct = 4'h0;
      default: oeAct = IDLE_OE;
    endcase
  end

  // Every pin is a flop one cycle behind the sequencer, so pins move together.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flashSclk_r <= 1'b0;
      flashSel_r <= 3'h7;
      flashIo_r <= IDLE_IO;
      flashOe_r <= IDLE_OE;
      touchSclk_r <= 1'b0;
      touchSel_r <= 1'b1;
      touchIo_r <= IDLE_IO;
      touchOe_r <= IDLE_OE;
    end else begin
      flashSclk_r <= flashAct && sclk_r;
      flashSel_r <= ~(flashAct ? 3'h1 << cmd_r.target : 3'h0);
      flashIo_r <= flashAct ? (drv & oeAct) : IDLE_IO;
      flashOe_r <= flashAct ? oeAct : IDLE_OE;
      touchSclk_r <= touchAct && sclk_r;
      touchSel_r <= ~touchAct;
      touchIo_r <= touchAct ? (drv & oeAct) : IDLE_IO;
      touchOe_r <= touchAct ? oeAct : IDLE_OE;
    end
  end

  assign cmdReady = cmdReady_r;
  assign cmdReject = cmdReject_r;
  assign cmdDone = cmdDone_r;
  assign txReady = waitTx_r;
  assign flashPortSerialClock = flashSclk_r;
  assign primaryFlashSelectN = flashSel_r[0];
  assign secondaryFlashSelectN = flashSel_r[1];
  assign trustedModuleSelectN = flashSel_r[2];
  assign flashPortOutLineDrive = flashIo_r[0];
  assign flashPortOutLineEnable = flashOe_r[0];
  assign flashPortInLineDrive = flashIo_r[1];
  assign flashPortInLineEnable = flashOe_r[1];
  assign flashPortUpperDataDrive = flashIo_r[3:2];
  assign flashPortUpperDataEnable = flashOe_r[3:2];
  assign touchPortSerialClock = touchSclk_r;
  assign touchDeviceSelectN = touchSel_r;
  assign touchPortOutLineDrive = touchIo_r[0];
  assign touchPortOutLineEnable = touchOe_r[0];
  assign touchPortInLineDrive = touchIo_r[1];
  assign touchPortInLineEnable = touchOe_r[1];
  assign touchPortDataBit2Drive = touchIo_r[2];
  assign touchPortDataBit2Enable = touchOe_r[2];
  assign touchPortDataBit3Drive = touchIo_r[3];
  assign touchPortDataBit3Enable = touchOe_r[3];

endmodule : sft_port

// file: sft_port_chk.sv
`timescale 1ns/1ps
module sft_port_chk
  import sft_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Controls.
  input wire logic [1:0] rateSel,
  input wire logic strapTrustedOnPort,
  input wire logic strapFlashMultiLine,
  input wire logic cmdValid,
  input wire sft_cmd_s cmd,
  input wire logic cmdReady,
  input wire logic cmdReject,
  input wire logic cmdDone,
  // Pins.
  input wire logic flashPortSerialClock,
  input wire logic primaryFlashSelectN,
  input wire logic secondaryFlashSelectN,
  input wire logic trustedModuleSelectN,
  input wire logic touchDeviceSelectN,
  input wire logic flashPortInLineEnable,
  input wire logic [1:0] flashPortUpperDataEnable,
  input wire logic touchPortInLineEnable,
  input wire logic touchPortDataBit2Enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] selN;
  assign selN = {touchDeviceSelectN, trustedModuleSelectN, secondaryFlashSelectN,
    primaryFlashSelectN};
  a_one_select_low: assert property ($countones(~selN) <= 1)
    else $error("two selects low together");
  a_start_delay: assert property (cmdValid && cmdReady |=> cmdReject or ##1 (selN != 4'hF))
    else $error("select did not fall two cycles after a legal command");
  a_done_idle: assert property (cmdDone |-> selN == 4'hF && !flashPortSerialClock)
    else $error("select or clock active at done");
  a_fast_half: assert property ($rose(flashPortSerialClock) && rateSel == RATE_FAST
    |-> flashPortSerialClock [*3] ##1 !flashPortSerialClock)
    else $error("fast clock high phase wrong");
  a_slow_half: assert property ($rose(flashPortSerialClock) && rateSel == RATE_SLOW
    |-> flashPortSerialClock [*7] ##1 !flashPortSerialClock)
    else $error("slow clock high phase wrong");
  a_reject_rate: assert property (cmdValid && cmdReady && rateSel == 2'h3 |=> cmdReject)
    else $error("illegal rate not refused");
  a_primary_only: assert property ($fell(primaryFlashSelectN) |-> cmd.target == TGT_PRIMARY)
    else $error("select zero for wrong target");
  a_secondary_only: assert property ($fell(secondaryFlashSelectN)
    |-> cmd.target == TGT_SECONDARY)
    else $error("select one for wrong target");
  a_trusted_only: assert property ($fell(trustedModuleSelectN)
    |-> cmd.target == TGT_TRUSTED && cmd.mode == MODE_SINGLE)
    else $error("select two for wrong target");
  a_trusted_strap: assert property (!trustedModuleSelectN |-> strapTrustedOnPort)
    else $error("select two without strap");
  a_touch_only: assert property ($fell(touchDeviceSelectN) |-> cmd.target == TGT_TOUCH)
    else $error("touch select for wrong target");
  a_in_strap: assert property (flashPortInLineEnable |-> strapFlashMultiLine)
    else $error("in line driven without strap");
  a_upper_strap: assert property (|flashPortUpperDataEnable |-> strapFlashMultiLine)
    else $error("upper lines driven without strap");
  a_touch_lines: assert property (touchPortInLineEnable || touchPortDataBit2Enable
    |-> !touchDeviceSelectN)
    else $error("touch line driven while deselected");
endmodule : sft_port_chk

bind sft_port sft_port_chk u_chk (.clk, .rst_n, .rateSel, .strapTrustedOnPort,
  .strapFlashMultiLine, .cmdValid, .cmd, .cmdReady, .cmdReject, .cmdDone,
  .flashPortSerialClock, .primaryFlashSelectN, .secondaryFlashSelectN,
  .trustedModuleSelectN, .touchDeviceSelectN, .flashPortInLineEnable,
  .flashPortUpperDataEnable, .touchPortInLineEnable, .touchPortDataBit2Enable);

// file: sft_tgt_model.sv
`timescale 1ns/1ps
module sft_tgt_model #(
  parameter bit PULL = 1'b1
) (
  // Clock and bus side.
  input wire logic clk,
  input wire logic sclk,
  input wire logic selN,
  input wire logic [3:0] oe,
  input wire logic [3:0] drv,
  // Resolved line levels.
  output logic [3:0] line
);
  int beat = 0;
  logic tog = 1'b0;
  // Every released line carries the beat count, so the bench can predict each lane.
  always @(negedge sclk or posedge selN) begin
    if (selN) beat <= 0;
    else beat <= beat + 1;
  end
  always @(posedge clk) tog <= ~tog;
  // Lines without a pull keep changing when nobody drives them.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe[i]) line[i] = drv[i];
      else if (!selN) line[i] = beat[i];
      else line[i] = PULL | tog;
    end
  end
endmodule : sft_tgt_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import sft_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] rateSel = 2'h0;
  logic strapT = 1'b0;
  logic strapM = 1'b0;
  logic cmdValid = 1'b0;
  sft_cmd_s cmd = '0;
  logic txValid = 1'b0;
  logic [7:0] txData = 8'h00;
  logic rxReady = 1'b0;
  logic cmdReady, cmdReject, cmdDone, txReady, rxValid, fClk, pSel, sSel, tSel, uClk, uSel;
  logic [7:0] rxData;
  logic [3:0] fOe, fDrv, fLine, uOe, uDrv, uLine;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] got[$];
  logic [7:0] exp[$];
  logic [7:0] sent[$];
  logic [63:0] wsh = '0;
  int tg[9] = '{0, 1, 0, 1, 0, 2, 3, 3, 3};
  int md[9] = '{0, 1, 2, 3, 4, 0, 0, 2, 4};
  always #2 clk = ~clk;
  sft_port u_sft_port (.clk(clk), .rst_n(rst_n), .rateSel(rateSel),
    .strapTrustedOnPort(strapT), .strapFlashMultiLine(strapM), .cmdValid(cmdValid),
    .cmd(cmd), .cmdReady(cmdReady), .cmdReject(cmdReject), .cmdDone(cmdDone),
    .txValid(txValid), .txData(txData), .txReady(txReady), .rxValid(rxValid),
    .rxData(rxData), .rxReady(rxReady), .flashPortSerialClock(fClk),
    .primaryFlashSelectN(pSel), .secondaryFlashSelectN(sSel), .trustedModuleSelectN(tSel),
    .flashPortOutLineDrive(fDrv[0]), .flashPortOutLineEnable(fOe[0]),
    .flashPortOutLineSense(fLine[0]), .flashPortInLineDrive(fDrv[1]),
    .flashPortInLineEnable(fOe[1]), .flashPortInLineSense(fLine[1]),
    .flashPortUpperDataDrive(fDrv[3:2]), .flashPortUpperDataEnable(fOe[3:2]),
    .flashPortUpperDataSense(fLine[3:2]), .touchPortSerialClock(uClk),
    .touchDeviceSelectN(uSel), .touchPortOutLineDrive(uDrv[0]),
    .touchPortOutLineEnable(uOe[0]), .touchPortOutLineSense(uLine[0]),
    .touchPortInLineDrive(uDrv[1]), .touchPortInLineEnable(uOe[1]),
    .touchPortInLineSense(uLine[1]), .touchPortDataBit2Drive(uDrv[2]),
    .touchPortDataBit2Enable(uOe[2]), .touchPortDataBit2Sense(uLine[2]),
    .touchPortDataBit3Drive(uDrv[3]), .touchPortDataBit3Enable(uOe[3]),
    .touchPortDataBit3Sense(uLine[3]));
  sft_tgt_model #(.PULL(1'b1)) u_flash (.clk(clk), .sclk(fClk), .selN(pSel & sSel & tSel),
    .oe(fOe), .drv(fDrv), .line(fLine));
  sft_tgt_model #(.PULL(1'b0)) u_touch (.clk(clk), .sclk(uClk), .selN(uSel),
    .oe(uOe), .drv(uDrv), .line(uLine));
  // The reader stalls at random to fill the two-entry buffer.
  always @(posedge clk) begin
    if (rxValid === 1'b1 && rxReady) got.push_back(rxData);
    if (txValid && txReady === 1'b1) sent.push_back(txData);
    rxReady <= 1'($urandom_range(3) != 0);
    if (!txValid || txReady === 1'b1) begin
      txValid <= 1'($urandom);
      txData <= 8'($urandom);
    end
  end
  // The out line as the flash sees it at each rising clock edge.
  always @(posedge fClk) wsh <= {wsh[62:0], fLine[0]};
  task automatic cmpB(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: byte %h expected %h", $time, g, e);
    end
  endtask : cmpB
  task automatic cmpF(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: flag %b expected %b", $time, g, e);
    end
  endtask : cmpF
  function automatic void model(input sft_cmd_s c);
    int a, d, s, v, nn;
    a = (c.mode == MODE_DUAL_IO) ? 2 : (c.mode == MODE_QUAD_IO) ? 4 : 1;
    d = (c.mode inside {MODE_DUAL_OUT, MODE_DUAL_IO}) ? 2 : (c.mode >= MODE_QUAD_OUT) ? 4 : 1;
    s = 8 + int'(c.addrBytes) * 8 / a + int'(c.dummy);
    if (c.dummy == 4'h0 && !c.isWrite && c.mode != MODE_SINGLE) s++;
    exp.delete();
    for (int j = 0; j < int'(c.len) && !c.isWrite; j++) begin
      v = 0;
      for (int b = 0; b < 8 / d; b++) begin
        nn = s + j * 8 / d + b;
        v = (v << d) | ((d == 1) ? (nn >> 1) & 1 : nn & ((1 << d) - 1));
      end
      exp.push_back(8'(v));
    end
  endfunction : model
  task automatic go(input sft_cmd_s c, output logic r, output logic dn);
    int n;
    model(c);
    got.delete();
    sent.delete();
    @(posedge clk);
    cmdValid <= 1'b1;
    cmd <= c;
    do @(posedge clk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmdDone !== 1'b1 && cmdReject !== 1'b1 && n < 5000);
    r = cmdReject;
    dn = cmdDone;
    n = 0;
    while (got.size() < exp.size() && n < 500) begin
      @(posedge clk);
      n++;
    end
    $display("test ended at %0t", $time);
  endtask : go
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    sft_cmd_s c;
    logic r, dn;
    logic [31:0] m;
    void'($urandom(75904));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = '{TGT_PRIMARY, MODE_SINGLE, 1'b0, 3'h3, 4'h1, 8'h0B, 32'h0, 16'h1};
      rateSel <= (i == 0) ? 2'h3 : 2'h2;
      strapT <= (i == 5);
      case (i)
        1: c.addrBytes = 3'h2;
        2: c.addr = 32'h0100_0000;
        3: c = '{TGT_PRIMARY, MODE_SINGLE, 1'b0, 3'h4, 4'h1, 8'h0B, 32'h0400_0000, 16'h1};
        4: c.target = TGT_TRUSTED;
        5: c = '{TGT_TRUSTED, MODE_DUAL_OUT, 1'b0, 3'h3, 4'h1, 8'h0B, 32'h0, 16'h1};
        6: c = '{TGT_TOUCH, MODE_QUAD_OUT, 1'b0, 3'h3, 4'h1, 8'h0B, 32'h0, 16'h1};
        7: c.mode = MODE_QUAD_IO;
        default: c.len = 16'h1;
      endcase
      go(c, r, dn);
      cmpF(r, 1'b1);
    end
    strapM <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rateSel <= 2'(i % 3);
      strapT <= 1'b1;
      m = (i % 2) ? 32'h03FF_FFFF : 32'h00FF_FFFF;
      c.target = sft_target_e'(tg[i % 9]);
      c.mode = sft_mode_e'(md[i % 9]);
      c.isWrite = (i == 9);
      c.addrBytes = (i % 2) ? 3'h4 : 3'h3;
      c.addr = (i < 2) ? m : $urandom & m;
      c.dummy = 4'($urandom_range(4, 0));
      c.len = 16'($urandom_range(6, 1));
      go(c, r, dn);
      cmpF(dn, 1'b1);
      foreach (exp[k]) cmpB((got.size() > k) ? got[k] : 8'hXX, exp[k]);
      if (c.isWrite) cmpB(8'(sent.size()), 8'(c.len));
      foreach (sent[k]) cmpB(wsh[8 * (sent.size() - 1 - k) +: 8], sent[k]);
    end
    tally_and_finish();
  end
endmodule : testbench
